//--- core/mbrm_core.sv
// Modbus RTU slave serving read-only float and scaled integer measurement registers.
// Function
// - Default link is 19200 bit/s, 8 data, no parity, 2 stop, station 240.
// - Serve read holding registers and device identification; write multiple registers gets illegal address.
// - Each quantity sits in both a float register pair and an integer register.
// - Float registers carry single-precision binary32 values.
// - A 32-bit value puts its low word first, high word at next address.
// - Integer codes 0000..7ffe are the value; 7fff means 32767 or more.
// - Code 8001 means -32767 or less; 8002..ffff are -32766..-1.
// - Code 8000 means the quantity is currently unavailable.
// - Integer registers are scaled by a fixed per-register factor.
// - Register number N is reached at message address N minus one.
// - Float measurement registers are read-only pairs from 0000, temperature at 0002.
// - Integer measurement registers are read-only from 0100, humidity and temperature x100.
`timescale 1ns/100ps
module mbrm_core import mbrm_pkg::*; #(
  parameter int         BIT_CYC    = BIT_CYCLES,
  parameter logic [7:0] STATION    = STATION_DEFAULT,
  parameter logic [7:0] VENDOR_TAG = 8'h5a  // Arbitrary identity value
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  rx_i,
  input  wire logic [NUM_QTY*32-1:0] meas_float_i,
  input  wire logic [NUM_QTY*32-1:0] meas_fixed_i,
  input  wire logic [NUM_QTY-1:0]    meas_avail_i,
  output logic                       tx_o,
  output logic                       tx_en_o
);

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CYC / 2);
  localparam logic [19:0] GAP_LAST = 20'(GAP_BITS * BIT_CYC - 1);
  localparam logic [3:0]  TX_BITS  = 4'(FRAME_BITS);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  function automatic logic [15:0] mbrm_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : mbrm_crc_step

  function automatic logic [15:0] mbrm_sat16(input logic signed [31:0] v, input logic avail);
    if (!avail) return INT_NA_CODE;
    if (v >= SAT_POS_LIM) return INT_POS_SAT;
    if (v <= SAT_NEG_LIM) return INT_NEG_SAT;
    return v[15:0];
  endfunction : mbrm_sat16

  // Receive line: three stages, a level counts once stages two and three agree
  logic [2:0]  rx_sync_reg;
  logic        rx_line_reg;
  mbrm_rx_e    rx_state_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0]  rx_bit_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_stb_reg;
  logic        rx_stop_ok_reg;
  logic [19:0] idle_cnt_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_sync_reg <= 3'h7;
      rx_line_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], rx_i};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_line_reg <= rx_sync_reg[2];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state_reg   <= RX_IDLE;
      rx_cnt_reg     <= 16'h0000;
      rx_bit_reg     <= 3'h0;
      rx_shift_reg   <= 8'h00;
      rx_stb_reg     <= 1'b0;
      rx_stop_ok_reg <= 1'b0;
    end else begin
      rx_stb_reg <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 16'h0000;
          if (!rx_line_reg) rx_state_reg <= RX_START;
        end
        RX_START: begin
          // Start bit is checked at its middle to reject glitches
          if (rx_cnt_reg == BIT_HALF) begin
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= rx_line_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt_reg == BIT_LAST) begin
            rx_cnt_reg   <= 16'h0000;
            rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked; the second looks like idle line
          if (rx_cnt_reg == BIT_LAST) begin
            rx_stb_reg     <= 1'b1;
            rx_stop_ok_reg <= rx_line_reg;
            rx_state_reg   <= RX_IDLE;
          end
        end
      endcase
    end
  end

  wire rx_quiet = (rx_state_reg == RX_IDLE) && rx_line_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt_reg <= 20'h00000;
    end else if (!rx_quiet) begin
      idle_cnt_reg <= 20'h00000;
    end else if (idle_cnt_reg != GAP_LAST) begin
      idle_cnt_reg <= idle_cnt_reg + 20'h00001;
    end
  end

  // Frame collection
  mbrm_state_e state_reg;
  mbrm_kind_e  kind_reg;
  logic [7:0]  hdr_reg [0:7];
  logic [7:0]  byte_cnt_reg;
  logic [15:0] rx_crc_reg;
  logic        frame_err_reg;
  logic [7:0]  fc_reg;
  logic [7:0]  exc_reg;
  logic [7:0]  read_code_reg;
  logic [15:0] start_reg;
  logic [15:0] qty_reg;
  logic [15:0] scan_addr_reg;
  logic [15:0] scan_left_reg;
  logic [7:0]  tx_idx_reg;
  logic [15:0] tx_crc_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [15:0] tx_cnt_reg;
  logic        tx_en_reg;

  wire frame_end = rx_quiet && (idle_cnt_reg == GAP_LAST - 20'h00001) && (byte_cnt_reg != 8'h00);
  // Residue of zero over body plus checksum means an intact frame
  wire frame_ok  = (rx_crc_reg == 16'h0000) && !frame_err_reg && (hdr_reg[0] == STATION);

  wire [7:0]  req_fc     = hdr_reg[1];
  wire [15:0] req_start  = {hdr_reg[2], hdr_reg[3]};
  wire [15:0] req_qty    = {hdr_reg[4], hdr_reg[5]};
  wire        req_qty_ok = (byte_cnt_reg == READ_REQ_LEN) && (req_qty != 16'h0000) && (req_qty <= MAX_READ_QTY);
  wire        req_is_id  = (req_fc == FC_DEV_ID) && (hdr_reg[2] == MEI_DEV_ID);
  // Nothing in this map is writable, so write multiple registers names an illegal address
  wire [7:0]  req_exc    = (req_fc == FC_READ_HOLD)   ? (req_qty_ok ? EXC_NONE : EXC_ILL_VALUE) :
                           (req_fc == FC_WRITE_MULTI) ? EXC_ILL_ADDR :
                           req_is_id                  ? EXC_NONE : EXC_ILL_FUNC;
  wire mbrm_kind_e req_kind = (req_exc != EXC_NONE) ? K_EXC : (req_fc == FC_READ_HOLD) ? K_READ : K_ID;

  // Address decode, shared by the pre-scan and the answer
  wire [7:0]  data_idx  = tx_idx_reg - RESP_HDR_LEN;
  wire [15:0] send_addr = start_reg + {8'h00, 1'b0, data_idx[7:1]};
  wire [15:0] dec_addr  = (state_reg == ST_CHECK) ? scan_addr_reg : send_addr;

  logic [NUM_QTY-1:0] flt_hit;
  logic [NUM_QTY-1:0] int_hit;
  logic [15:0]        flt_chain [0:NUM_QTY];
  logic [15:0]        int_chain [0:NUM_QTY];
  assign flt_chain[0] = 16'h0000;
  assign int_chain[0] = 16'h0000;

  for (genvar q = 0; q < NUM_QTY; q++) begin : g_qty
    wire signed [31:0] raw    = $signed(meas_fixed_i[q*32 +: 32]);
    wire signed [31:0] scaled = raw / INT_DIV[q];
    wire [15:0]        code   = mbrm_sat16(scaled, meas_avail_i[q]);
    wire [15:0]        fword  = dec_addr[0] ? meas_float_i[q*32+16 +: 16] : meas_float_i[q*32 +: 16];
    // Addresses are zero based on the wire
    assign flt_hit[q]     = (dec_addr[15:1] == FLT_OFS[q][15:1]);
    assign int_hit[q]     = (dec_addr == INT_OFS[q]);
    assign flt_chain[q+1] = flt_chain[q] | (flt_hit[q] ? fword : 16'h0000);
    assign int_chain[q+1] = int_chain[q] | (int_hit[q] ? code : 16'h0000);

    a_sat_high: assert property (meas_avail_i[q] && scaled >= SAT_POS_LIM |-> code == 16'h7fff)
      else $error("integer above range not saturated to 7fff");
    a_sat_low: assert property (meas_avail_i[q] && scaled <= SAT_NEG_LIM |-> code == 16'h8001)
      else $error("integer below range not saturated to 8001");
    a_not_avail: assert property (!meas_avail_i[q] |-> code == 16'h8000)
      else $error("unavailable quantity not coded 8000");
    a_in_range: assert property (meas_avail_i[q] && scaled < SAT_POS_LIM && scaled > SAT_NEG_LIM
                                 |-> code == scaled[15:0])
      else $error("in-range integer altered");
    a_low_first: assert property (flt_hit[q] && !dec_addr[0] |-> flt_chain[NUM_QTY] == meas_float_i[q*32 +: 16])
      else $error("float low word not at listed address");
  end

  wire        dec_hit  = (|flt_hit) || (|int_hit);
  wire [15:0] dec_word = flt_chain[NUM_QTY] | int_chain[NUM_QTY];

  // Answer byte generator
  wire [7:0] body_len  = (kind_reg == K_READ) ? RESP_HDR_LEN + {qty_reg[6:0], 1'b0} :
                         (kind_reg == K_EXC)  ? RESP_HDR_LEN : ID_RESP_LEN;
  wire [7:0] read_byte = (tx_idx_reg == 8'h01) ? FC_READ_HOLD :
                         (tx_idx_reg == 8'h02) ? {qty_reg[6:0], 1'b0} :
                         data_idx[0] ? dec_word[7:0] : dec_word[15:8];
  wire [7:0] exc_byte  = (tx_idx_reg == 8'h01) ? (fc_reg | FC_EXC_FLAG) : exc_reg;
  logic [7:0] id_bytes [0:15];
  assign id_bytes = '{STATION, FC_DEV_ID, MEI_DEV_ID, read_code_reg, ID_CONFORMITY, ID_MORE_NONE, ID_MORE_NONE,
                      ID_NUM_OBJECTS, ID_OBJ_VENDOR, ID_OBJ_LEN, VENDOR_TAG, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  wire [7:0] body_byte = (tx_idx_reg == 8'h00) ? STATION :
                         (kind_reg == K_READ)  ? read_byte :
                         (kind_reg == K_EXC)   ? exc_byte : id_bytes[tx_idx_reg[3:0]];
  wire [7:0] out_byte  = (tx_idx_reg < body_len) ? body_byte :
                         (tx_idx_reg == body_len) ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
  wire tx_busy = (tx_bits_reg != 4'h0);
  wire tx_last = (tx_idx_reg == body_len + 8'h02);
  wire tx_load = (state_reg == ST_SEND) && !tx_busy && !tx_last;
  wire tx_done = (state_reg == ST_SEND) && !tx_busy && tx_last;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_cnt_reg  <= 8'h00;
      rx_crc_reg    <= CRC_INIT;
      frame_err_reg <= 1'b0;
      for (int i = 0; i < 8; i++) hdr_reg[i] <= 8'h00;
    end else if (state_reg != ST_LISTEN || frame_end) begin
      byte_cnt_reg  <= 8'h00;
      rx_crc_reg    <= CRC_INIT;
      frame_err_reg <= 1'b0;
    end else if (rx_stb_reg) begin
      rx_crc_reg <= mbrm_crc_step(rx_crc_reg, rx_shift_reg);
      if (!rx_stop_ok_reg) frame_err_reg <= 1'b1;
      if (byte_cnt_reg < 8'h08) hdr_reg[byte_cnt_reg[2:0]] <= rx_shift_reg;
      if (byte_cnt_reg != 8'hff) byte_cnt_reg <= byte_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg     <= ST_LISTEN;
      kind_reg      <= K_EXC;
      fc_reg        <= 8'h00;
      exc_reg       <= EXC_NONE;
      read_code_reg <= 8'h00;
      start_reg     <= 16'h0000;
      qty_reg       <= 16'h0000;
      scan_addr_reg <= 16'h0000;
      scan_left_reg <= 16'h0000;
      tx_idx_reg    <= 8'h00;
      tx_crc_reg    <= CRC_INIT;
    end else begin
      unique case (state_reg)
        ST_LISTEN: begin
          tx_idx_reg <= 8'h00;
          tx_crc_reg <= CRC_INIT;
          // Frames for other stations or with bad checksum get no answer
          if (frame_end && frame_ok) begin
            fc_reg        <= req_fc;
            exc_reg       <= req_exc;
            kind_reg      <= req_kind;
            read_code_reg <= hdr_reg[3];
            start_reg     <= req_start;
            qty_reg       <= req_qty;
            scan_addr_reg <= req_start;
            scan_left_reg <= req_qty;
            state_reg     <= (req_kind == K_READ) ? ST_CHECK : ST_SEND;
          end
        end
        ST_CHECK: begin
          // Whole range is checked first so an exception never follows partial data
          if (!dec_hit) begin
            kind_reg  <= K_EXC;
            exc_reg   <= EXC_ILL_ADDR;
            state_reg <= ST_SEND;
          end else if (scan_left_reg == 16'h0001) begin
            state_reg <= ST_SEND;
          end else begin
            scan_addr_reg <= scan_addr_reg + 16'h0001;
            scan_left_reg <= scan_left_reg - 16'h0001;
          end
        end
        ST_SEND: begin
          if (tx_load) begin
            tx_idx_reg <= tx_idx_reg + 8'h01;
            if (tx_idx_reg < body_len) tx_crc_reg <= mbrm_crc_step(tx_crc_reg, body_byte);
          end
          if (tx_done) state_reg <= ST_LISTEN;
        end
      endcase
    end
  end

  // Transmitter: start bit, 8 data bits LSB first, two stop bits, no parity
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_shift_reg <= 11'h7ff;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 16'h0000;
      tx_en_reg    <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= {2'b11, out_byte, 1'b0};
      tx_bits_reg  <= TX_BITS;
      tx_cnt_reg   <= 16'h0000;
      tx_en_reg    <= 1'b1;
    end else if (tx_busy) begin
      tx_cnt_reg <= tx_cnt_reg + 16'h0001;
      if (tx_cnt_reg == BIT_LAST) begin
        tx_cnt_reg   <= 16'h0000;
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
      end
    end else if (tx_done) begin
      tx_en_reg <= 1'b0;
    end
  end

  assign tx_o    = tx_shift_reg[0];
  assign tx_en_o = tx_en_reg;

  sequence s_accept;
    state_reg == ST_LISTEN && frame_end && frame_ok;
  endsequence
  sequence s_read_ok;
    s_accept ##0 req_fc == FC_READ_HOLD ##0 req_qty_ok;
  endsequence

  a_idle_mark: assert property (!tx_en_o |-> tx_o)
    else $error("line not marking while driver is off");
  a_char_frame: assert property (tx_load |=> !tx_o && tx_shift_reg[10:9] == 2'b11 && tx_bits_reg == 4'hb)
    else $error("character not framed with start and two stop bits");
  a_station_first: assert property (tx_load && tx_idx_reg == 8'h00 |-> out_byte == STATION)
    else $error("answer does not open with station address");
  a_read_scan: assert property (s_read_ok |=> state_reg == ST_CHECK && kind_reg == K_READ)
    else $error("valid read not accepted");
  a_dev_ident: assert property (s_accept ##0 req_is_id |=> state_reg == ST_SEND && kind_reg == K_ID)
    else $error("identification request not answered");
  a_write_ro: assert property (s_accept ##0 req_fc == FC_WRITE_MULTI |=> kind_reg == K_EXC && exc_reg == 8'h02)
    else $error("write to read-only map not refused");
  a_unmapped: assert property (state_reg == ST_CHECK && !dec_hit |=> state_reg == ST_SEND ##0 exc_reg == 8'h02)
    else $error("unmapped address not refused");
  a_exc_func: assert property (tx_load && kind_reg == K_EXC && tx_idx_reg == 8'h01
                               |-> out_byte == (fc_reg | 8'h80))
    else $error("exception answer lacks flagged function code");
  a_reply_start: assert property (s_accept |-> ##[1:300] tx_en_o)
    else $error("accepted frame not answered in time");

endmodule : mbrm_core

//--- core/mbrm_pkg.sv
// Constants, tables and types of the measurement register front end.
package mbrm_pkg;

  // Line framing, 8N2 at 19200 bit/s
  localparam int         CLK_FREQ_HZ     = 100_000_000;
  localparam int         BAUD_RATE       = 19200;
  localparam int         BIT_CYCLES      = CLK_FREQ_HZ / BAUD_RATE;
  localparam int         DATA_BITS       = 8;
  localparam int         STOP_BITS       = 2;
  localparam int         FRAME_BITS      = 1 + DATA_BITS + STOP_BITS;
  // Silence that ends a frame: 3.5 characters, in bit times, rounded up
  localparam int         GAP_BITS        = (35 * FRAME_BITS + 9) / 10;
  localparam logic [7:0] STATION_DEFAULT = 8'hf0;

  // Function codes and exception codes
  localparam logic [7:0] FC_READ_HOLD    = 8'h03;
  localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;
  localparam logic [7:0] FC_DEV_ID       = 8'h2b;
  localparam logic [7:0] MEI_DEV_ID      = 8'h0e;
  localparam logic [7:0] FC_EXC_FLAG     = 8'h80;
  localparam logic [7:0] EXC_NONE        = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE   = 8'h03;
  localparam logic [15:0] MAX_READ_QTY   = 16'h007d;
  localparam logic [7:0] READ_REQ_LEN    = 8'h08;

  // Answer layout
  localparam logic [7:0] RESP_HDR_LEN    = 8'h03;
  localparam logic [7:0] ID_RESP_LEN     = 8'h0b;
  localparam logic [7:0] ID_CONFORMITY   = 8'h01;
  localparam logic [7:0] ID_MORE_NONE    = 8'h00;
  localparam logic [7:0] ID_NUM_OBJECTS  = 8'h01;
  localparam logic [7:0] ID_OBJ_VENDOR   = 8'h00;
  localparam logic [7:0] ID_OBJ_LEN      = 8'h01;

  // Checksum
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;

  // Integer codes
  localparam logic [15:0] INT_NA_CODE    = 16'h8000;
  localparam logic [15:0] INT_POS_SAT    = 16'h7fff;
  localparam logic [15:0] INT_NEG_SAT    = 16'h8001;
  localparam logic signed [31:0] SAT_POS_LIM = 32'sh0000_7fff;
  localparam logic signed [31:0] SAT_NEG_LIM = -32'sh0000_7fff;

  // Quantity tables, same order for both formats
  localparam int NUM_QTY = 21;
  localparam logic [15:0] FLT_OFS [0:NUM_QTY-1] = '{
    16'h0000, 16'h0002, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
    16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0028, 16'h002a, 16'h002c, 16'h0040};
  localparam logic [15:0] INT_OFS [0:NUM_QTY-1] = '{
    16'h0100, 16'h0101, 16'h0103, 16'h0104, 16'h0105, 16'h0106, 16'h0107, 16'h0108, 16'h0109, 16'h010a, 16'h010b,
    16'h010c, 16'h010d, 16'h010e, 16'h010f, 16'h0110, 16'h0111, 16'h0114, 16'h0115, 16'h0116, 16'h0120};
  // Divisor applied to the x100 input to reach each register's own scale
  localparam logic signed [31:0] INT_DIV [0:NUM_QTY-1] = '{
    32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh1, 32'sh64, 32'sha,
    32'sha, 32'sh1, 32'sh64, 32'sha, 32'sh1, 32'sh64, 32'sh1, 32'sh1, 32'sh1, 32'sh64};

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbrm_rx_e;
  typedef enum logic [1:0] {ST_LISTEN, ST_CHECK, ST_SEND} mbrm_state_e;
  typedef enum logic [1:0] {K_READ, K_EXC, K_ID} mbrm_kind_e;

endpackage : mbrm_pkg

//--- testbench/mbrm_master.sv
// Modbus master model: sends whole RTU request frames and collects reply bytes.
`timescale 1ns/100ps
module mbrm_master #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       ref_clk_i,
  input  wire logic       tx_i,
  input  wire logic       tx_en_i,
  output logic            line_o,
  output logic [7:0]      byte_o,
  output logic            byte_stb_o
);
  initial line_o = 1'b1;

  function automatic logic [15:0] crc16(input logic [7:0] m[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (m[i]) begin
      c = c ^ {8'h00, m[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // Start, 8 data LSB first, 2 stop; a spoiled checksum is the only fault it makes
  task automatic send_frame(input logic [7:0] m[$], input logic bad);
    logic [15:0] c;
    c = crc16(m) ^ {15'h0000, bad};
    m.push_back(c[7:0]);
    m.push_back(c[15:8]);
    @(posedge ref_clk_i);
    foreach (m[i]) for (int b = -1; b < 10; b++) begin
      #1 line_o = (b < 0) ? 1'b0 : (b > 7) ? 1'b1 : m[i][b[2:0]];
      repeat (BIT_CYC) @(posedge ref_clk_i);
    end
  endtask : send_frame

  initial begin
    byte_o = 8'h00;
    byte_stb_o = 1'b0;
    forever begin
      @(negedge tx_i);
      repeat (BIT_CYC / 2) @(posedge ref_clk_i);
      for (int b = 0; b < 9; b++) begin
        repeat (BIT_CYC) @(posedge ref_clk_i);
        if (b < 8) byte_o[b] = tx_i;
      end
      // Bad stop bit or driver off spoils the byte so the bench cannot miss it
      if (tx_i !== 1'b1 || tx_en_i !== 1'b1) byte_o = ~byte_o;
      #1 byte_stb_o = 1'b1;
      @(posedge ref_clk_i);
      #1 byte_stb_o = 1'b0;
    end
  end
endmodule : mbrm_master

//--- testbench/modbus_measurement_register_map_tb_top.sv
// Self-checking bench for the measurement register front end.
`timescale 1ns/100ps
module modbus_measurement_register_map_tb_top;
  import mbrm_pkg::*;
  localparam int BC = 16;
  logic                  ref_clk_i, rstn_i, rx_i, tx_o, tx_en_o, stb;
  logic [7:0]            rb;
  logic [NUM_QTY*32-1:0] flt, fix;
  logic [NUM_QTY-1:0]    avl;
  logic [7:0]            exp_q[$];
  int                    error_cnt = 0;
  int                    n_compared = 0;
  int                    seed = 32'hfccabb68;

  mbrm_core #(.BIT_CYC(BC)) mbrm_core_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .rx_i(rx_i),
    .meas_float_i(flt), .meas_fixed_i(fix), .meas_avail_i(avl), .tx_o(tx_o), .tx_en_o(tx_en_o));
  mbrm_master #(.BIT_CYC(BC)) mbrm_master_i (.ref_clk_i(ref_clk_i), .tx_i(tx_o), .tx_en_i(tx_en_o),
    .line_o(rx_i), .byte_o(rb), .byte_stb_o(stb));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // An answer byte with nothing noted is forced to fail
  always @(posedge ref_clk_i)
    if (stb === 1'b1) chk({8'h00, rb}, (exp_q.size() > 0) ? {8'h00, exp_q.pop_front()} : 16'h0100);

  function automatic logic [15:0] exp_int(input int v, input int d, input logic av);
    int q;
    q = v / d;
    if (!av) return 16'h8000;
    if (q >= 32767) return 16'h7fff;
    if (q <= -32767) return 16'h8001;
    return q[15:0];
  endfunction : exp_int

  // Notes the answer with its checksum, sends the request, waits for the answer to end
  task automatic xact(input logic [7:0] req[$], input logic [7:0] rsp[$], input logic bad);
    logic [15:0] c;
    int          t;
    c = mbrm_master_i.crc16(rsp);
    if (rsp.size() > 0) begin
      rsp.push_back(c[7:0]);
      rsp.push_back(c[15:8]);
    end
    foreach (rsp[i]) exp_q.push_back(rsp[i]);
    mbrm_master_i.send_frame(req, bad);
    t = 0;
    while (tx_en_o !== 1'b1 && t < 1500) begin
      @(posedge ref_clk_i);
      t++;
    end
    while (tx_en_o === 1'b1 && t < 9000) begin
      @(posedge ref_clk_i);
      t++;
    end
    repeat (2 * BC) @(posedge ref_clk_i);
    chk(16'(exp_q.size()), 16'h0000);
  endtask : xact

  initial begin
    logic [31:0] f;
    logic [15:0] w0, w1;
    int          vals[7];
    int          q;
    vals = '{32766, 32767, -32766, -32767, -1, 5000000, 0};
    rstn_i = 1'b0;
    fix = '0;
    avl = '1;
    for (int i = 0; i < NUM_QTY; i++) flt[i*32 +: 32] = $random(seed);
    repeat (3) @(posedge ref_clk_i);
    chk({14'h0000, tx_en_o, tx_o}, 16'h0001);
    #1 rstn_i = 1'b1;
    repeat (700) @(posedge ref_clk_i);
    // Whole pairs are read as 32-bit values; the first read, of a fixed slot, confirms word order
    for (int k = 0; k < 4; k++) begin
      q = (k == 0) ? 0 : $unsigned($random(seed)) % NUM_QTY;
      f = flt[q*32 +: 32];
      xact('{8'hf0, 8'h03, FLT_OFS[q][15:8], FLT_OFS[q][7:0], 8'h00, 8'h02},
           '{8'hf0, 8'h03, 8'h04, f[15:8], f[7:0], f[31:24], f[23:16]}, 1'b0);
    end
    $display("test float_read done");
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk_i);
      #1 fix[31:0] = vals[k];
      fix[63:32] = -vals[k];
      avl[1:0] = (k == 6) ? 2'b10 : 2'b11;
      w0 = exp_int(vals[k], 1, avl[0]);
      w1 = exp_int(-vals[k], 1, avl[1]);
      xact('{8'hf0, 8'h03, 8'h01, 8'h00, 8'h00, 8'h02},
           '{8'hf0, 8'h03, 8'h04, w0[15:8], w0[7:0], w1[15:8], w1[7:0]}, 1'b0);
    end
    @(posedge ref_clk_i);
    #1 fix[9*32 +: 32] = 123456;
    fix[10*32 +: 32] = -123456;
    w0 = exp_int(123456, 100, 1'b1);
    w1 = exp_int(-123456, 10, 1'b1);
    xact('{8'hf0, 8'h03, 8'h01, 8'h0a, 8'h00, 8'h02},
         '{8'hf0, 8'h03, 8'h04, w0[15:8], w0[7:0], w1[15:8], w1[7:0]}, 1'b0);
    $display("test int_read done");
    xact('{8'hf0, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00}, '{8'hf0, 8'h90, 8'h02}, 1'b0);
    xact('{8'hf0, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'hf0, 8'h85, 8'h01}, 1'b0);
    xact('{8'hf0, 8'h03, 8'h00, 8'h04, 8'h00, 8'h02}, '{8'hf0, 8'h83, 8'h02}, 1'b0);
    xact('{8'hf0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'hf0, 8'h83, 8'h03}, 1'b0);
    xact('{8'hf0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7e}, '{8'hf0, 8'h83, 8'h03}, 1'b0);
    xact('{8'hf0, 8'h2b, 8'h0e, 8'h01, 8'h00},
         '{8'hf0, 8'h2b, 8'h0e, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h5a}, 1'b0);
    xact('{8'hf0, 8'h2b, 8'h0d, 8'h01, 8'h00}, '{8'hf0, 8'hab, 8'h01}, 1'b0);
    $display("test functions done");
    xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, '{}, 1'b0);
    xact('{8'hf0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, '{}, 1'b1);
    $display("test silent done");
    tally_and_finish();
  end

  // Whole run is near 75k cycles; the limit keeps even a hung run under 100k cycles
  initial begin
    #950_000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : modbus_measurement_register_map_tb_top
